/* File: design/msc_pkg.sv */
// Purpose: Shared constants and types for the motion sensor configuration bank
// Assumes: Register port carries byte-wide data at byte addresses
// Notes: Every offset, field position, reset value and timing count lives here
package msc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_THRESHOLD_LOW = 8'h26;
  localparam logic [7:0] ADDR_EVENT_COUNT = 8'h27;
  localparam logic [7:0] ADDR_FILTER = 8'h28;
  localparam logic [7:0] ADDR_FIFO_WMARK = 8'h29;
  localparam logic [7:0] ADDR_INT_MAP = 8'h2A;
  localparam logic [7:0] ADDR_SYNC = 8'h2B;

  // Reset values
  localparam logic [7:0] RST_THRESHOLD_LOW = 8'h00;
  localparam logic [7:0] RST_EVENT_COUNT = 8'h01;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_FIFO_WMARK = 8'h60;
  localparam logic [7:0] RST_INT_MAP = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;

  // Writable bit masks; everything else is reserved
  localparam logic [7:0] MASK_FILTER = 8'h7F;
  localparam logic [7:0] MASK_FIFO_WMARK = 8'h7F;
  localparam logic [7:0] MASK_SYNC = 8'h07;

  // Field positions
  localparam int HPF_LSB = 4;
  localparam int RATE_LSB = 0;
  localparam int PIN_ONE_LSB = 0;
  localparam int PIN_TWO_LSB = 4;
  localparam int EXT_CLOCK_BIT = 2;
  localparam int THRESH_DATA_LSB = 3;

  // Field encodings
  localparam logic [2:0] HPF_BYPASS = 3'h0;
  localparam logic [3:0] RATE_CODE_MAX = 4'hA;
  localparam logic [1:0] SYNC_INTERNAL = 2'h0;
  localparam logic [1:0] SYNC_EXT_DIRECT = 2'h1;
  localparam logic [1:0] SYNC_EXT_INTERP = 2'h2;

  // Timing: oscillator and fastest output rate
  localparam int MCLK_HZ = 25000000;
  localparam int FASTEST_RATE_HZ = 4000;
  localparam int FASTEST_LOWPASS_MHZ = 1000000;
  localparam int RATE_BASE_CYCLES = MCLK_HZ / FASTEST_RATE_HZ;
  // Interpolated ready delay, in oscillator cycles
  localparam int INTERP_DELAY_MIN = 14;
  localparam int INTERP_DELAY_MAX = 8204;
  localparam int INTERP_DELAY_STEP = (INTERP_DELAY_MAX - INTERP_DELAY_MIN) / 10;

  // High-pass corner as parts per hundred million of the output rate
  localparam logic [19:0] HIGHPASS_CORNER_SELECT_FRAC [1:6] = '{20'h3C4D8, 20'h0F284, 20'h03CB9,
    20'h00F16, 20'h003BA, 20'h000EE};

  typedef struct packed {
    logic signed [19:0] x;
    logic signed [19:0] y;
    logic signed [19:0] z;
  } msc_axes_s;

  typedef struct packed {
    logic data_ready;
    logic fifo_full;
    logic overrun;
    logic activity;
  } msc_events_s;

endpackage : msc_pkg

/* File: design/msc_sync_edge.sv */
// Purpose: Two-flop synchroniser with rising edge detect for a pin input
// Assumes: Pin is slower than half the clock rate
// Notes: The first flop feeds only the second flop
`timescale 1ns/1ps
module msc_sync_edge (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;

endmodule : msc_sync_edge

/* File: design/msc_activity.sv */
// Purpose: Activity detector: threshold compare and consecutive-event counter
// Assumes: One sample strobe per output sample
// Notes: A required count of zero behaves as one
`timescale 1ns/1ps
module msc_activity (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sample_valid,
  input wire msc_pkg::msc_axes_s axes,
  input wire logic [2:0] axis_enable,
  input wire logic [15:0] activity_threshold,
  input wire logic [7:0] activity_event_count,
  output logic activity
);
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [2:0] above;
  logic any_above;
  logic reached;
  logic [7:0] run_next;

  function automatic logic [15:0] magnitude(input logic signed [19:0] v);
    logic [19:0] a;
    a = v[19] ? 20'(-v) : 20'(v);
    magnitude = a[msc_pkg::THRESH_DATA_LSB +: 16];
  endfunction : magnitude

  // Unsigned magnitude, threshold bit 0 aligned with sample bit 3; strictly greater
  assign above[0] = axis_enable[0] & (magnitude(axes.x) > activity_threshold);
  assign above[1] = axis_enable[1] & (magnitude(axes.y) > activity_threshold);
  assign above[2] = axis_enable[2] & (magnitude(axes.z) > activity_threshold);
  assign any_above = |above;
  assign run_next = (run_q == 8'hFF) ? run_q : run_q + 8'h01;
  assign reached = any_above & (run_next >= activity_event_count);
  // Run restarts on any sample with no enabled axis above threshold
  assign run_d = any_above ? run_next : 8'h00;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      run_q <= 8'h00;
      activity <= 1'b0;
    end
    else if (clear)
    begin
      run_q <= 8'h00;
      activity <= 1'b0;
    end
    else
    begin
      activity <= sample_valid & reached;
      if (sample_valid)
      begin
        run_q <= run_d;
      end
    end
  end

endmodule : msc_activity

/* File: design/msc_config_regs.sv */
// Purpose: Configuration bank 0x26..0x2B of a three-axis motion sensor
// Assumes: Serial front end presents byte writes/reads as one-cycle strobes on mclk
// Notes: Threshold high byte, polarity, standby and FIFO state arrive as inputs
// Contract
// - Activity threshold is unsigned 16 bits; low byte at 0x26; strictly-greater test.
// - Threshold bit 0 lines up with sample bit 3, bit 15 with bit 18.
// - Activity declared after programmed consecutive above-threshold count; count resets to one.
// - High-pass filter bypassed when corner field bits 6:4 is zero.
// - High-pass corner codes 1..6 are fixed fractions of the output rate.
// - Rate code 0 is 4000 Hz/1000 Hz, each step halves, last code 1010.
// - FIFO full when stored samples reach 7-bit watermark, valid 1 to 96.
// - Watermark resets to 96 so its interrupt stays quiet.
// - Pin one: bits 0..3 enable ready, full, overrun, activity.
// - Pin two: bits 4..7 enable ready, full, overrun, activity.
// - Any enabled event asserts its pin; several may be enabled.
// - Sync code 00 uses internal timing; code 11 is reserved.
// - Sync code 01: ready coincides with each external sync pulse.
// - Sync code 10: interpolated, ready 14 to 8204 cycles after sync.
// - Sync bit 2 switches sample timing to the external clock; code applies it only to internal timing (codes 00 and 11).
// - Interrupt pins active low when polarity is 0, high when 1.
`timescale 1ns/1ps
module msc_config_regs #(
  parameter int RATE_BASE = msc_pkg::RATE_BASE_CYCLES,
  parameter int INTERP_MIN = msc_pkg::INTERP_DELAY_MIN,
  parameter int INTERP_STEP = msc_pkg::INTERP_DELAY_STEP
) (
  input wire logic mclk,
  input wire logic rst,
  // Register port from the serial front end
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Fields held elsewhere
  input wire logic [7:0] activity_threshold_high,
  input wire logic [2:0] activity_axis_enable,
  input wire logic interrupt_polarity,
  input wire logic standby,
  // Datapath side
  input wire logic sample_valid,
  input wire msc_pkg::msc_axes_s axes,
  input wire logic [6:0] fifo_sample_count,
  input wire logic buffer_overrun_event,
  // Pins, from outside the clock domain
  input wire logic sync_pin,
  input wire logic ext_clock_pin,
  // Outputs
  output logic sample_strobe,
  output logic data_ready,
  output logic interp_enable,
  output logic highpass_enable,
  output logic [2:0] highpass_corner_select,
  output logic [19:0] highpass_corner_fraction,
  output logic [3:0] rate_lowpass_select,
  output logic [31:0] lowpass_corner_mhz,
  output logic [31:0] output_sample_rate_mhz,
  output logic fifo_full,
  output logic activity,
  output logic interrupt_pin_one,
  output logic interrupt_pin_two
);
  localparam logic [31:0] RATE_BASE_W = 32'(RATE_BASE);
  localparam logic [31:0] RATE_MHZ_BASE = 32'(msc_pkg::FASTEST_RATE_HZ * 1000);

  logic [7:0] activity_threshold_low_q;
  logic [7:0] activity_event_count_q;
  logic [7:0] filter_q;
  logic [7:0] fifo_wmark_q;
  logic [7:0] int_map_q;
  logic [7:0] sync_q;

  // Address decode
  logic sel_thresh;
  logic sel_count;
  logic sel_filter;
  logic sel_wmark;
  logic sel_map;
  logic sel_sync;
  logic [7:0] read_mux;

  assign sel_thresh = reg_addr == msc_pkg::ADDR_THRESHOLD_LOW;
  assign sel_count = reg_addr == msc_pkg::ADDR_EVENT_COUNT;
  assign sel_filter = reg_addr == msc_pkg::ADDR_FILTER;
  assign sel_wmark = reg_addr == msc_pkg::ADDR_FIFO_WMARK;
  assign sel_map = reg_addr == msc_pkg::ADDR_INT_MAP;
  assign sel_sync = reg_addr == msc_pkg::ADDR_SYNC;

  // Registers are stored masked, so reserved bits never hold a one
  always_comb
  begin
    if (sel_thresh)
      read_mux = activity_threshold_low_q;
    else if (sel_count)
      read_mux = activity_event_count_q;
    else if (sel_filter)
      read_mux = filter_q;
    else if (sel_wmark)
      read_mux = fifo_wmark_q;
    else if (sel_map)
      read_mux = int_map_q;
    else if (sel_sync)
      read_mux = sync_q;
    else
      read_mux = 8'h00;
  end

  // Standby gating of writes is the host's job; this bank accepts them any time
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activity_threshold_low_q <= msc_pkg::RST_THRESHOLD_LOW;
      activity_event_count_q <= msc_pkg::RST_EVENT_COUNT;
      filter_q <= msc_pkg::RST_FILTER;
      fifo_wmark_q <= msc_pkg::RST_FIFO_WMARK;
      int_map_q <= msc_pkg::RST_INT_MAP;
      sync_q <= msc_pkg::RST_SYNC;
    end
    else if (reg_write)
    begin
      if (sel_thresh)
        activity_threshold_low_q <= reg_wdata;
      if (sel_count)
        activity_event_count_q <= reg_wdata;
      if (sel_filter)
        filter_q <= reg_wdata & msc_pkg::MASK_FILTER;
      if (sel_wmark)
        fifo_wmark_q <= reg_wdata & msc_pkg::MASK_FIFO_WMARK;
      if (sel_map)
        int_map_q <= reg_wdata;
      if (sel_sync)
        sync_q <= reg_wdata & msc_pkg::MASK_SYNC;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= read_mux;
    end
  end

  // Filter decode
  logic [2:0] hpf_code;
  logic [3:0] rate_raw;
  logic [3:0] rate_code;

  assign hpf_code = filter_q[msc_pkg::HPF_LSB +: 3];
  assign rate_raw = filter_q[msc_pkg::RATE_LSB +: 4];
  // Codes above the last documented one behave as the slowest rate
  assign rate_code = (rate_raw > msc_pkg::RATE_CODE_MAX) ? msc_pkg::RATE_CODE_MAX : rate_raw;

  function automatic logic [19:0] hpf_fraction(input logic [2:0] code);
    if (code == 3'h0 || code == 3'h7)
      hpf_fraction = 20'h00000;
    else
      hpf_fraction = msc_pkg::HIGHPASS_CORNER_SELECT_FRAC[code];
  endfunction : hpf_fraction

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      highpass_enable <= 1'b0;
      highpass_corner_select <= 3'h0;
      highpass_corner_fraction <= 20'h00000;
      rate_lowpass_select <= 4'h0;
      lowpass_corner_mhz <= 32'h00000000;
      output_sample_rate_mhz <= 32'h00000000;
    end
    else
    begin
      highpass_enable <= hpf_code != msc_pkg::HPF_BYPASS;
      highpass_corner_select <= hpf_code;
      highpass_corner_fraction <= hpf_fraction(hpf_code);
      rate_lowpass_select <= rate_code;
      lowpass_corner_mhz <= 32'(msc_pkg::FASTEST_LOWPASS_MHZ) >> rate_code;
      output_sample_rate_mhz <= RATE_MHZ_BASE >> rate_code;
    end
  end

  // Pin inputs
  logic sync_rise;
  logic ext_clock_rise;

  msc_sync_edge u_sync_pin (
    .mclk(mclk),
    .rst(rst),
    .pin(sync_pin),
    .level(),
    .rise(sync_rise)
  );

  msc_sync_edge u_ext_clock_pin (
    .mclk(mclk),
    .rst(rst),
    .pin(ext_clock_pin),
    .level(),
    .rise(ext_clock_rise)
  );

  // Sample timing
  logic [1:0] sync_mode;
  logic ext_clock_sel;
  logic timer_step;
  logic [31:0] rate_period;
  logic [31:0] rate_cnt_q;
  logic rate_wrap;
  logic internal_tick;

  assign sync_mode = sync_q[1:0];
  assign ext_clock_sel = sync_q[msc_pkg::EXT_CLOCK_BIT];
  // External clock edges replace oscillator cycles as the timebase
  assign timer_step = ext_clock_sel ? ext_clock_rise : 1'b1;
  assign rate_period = RATE_BASE_W << rate_code;
  assign rate_wrap = rate_cnt_q >= rate_period - 32'h00000001;
  assign internal_tick = timer_step & rate_wrap;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rate_cnt_q <= 32'h00000000;
    else if (standby)
      rate_cnt_q <= 32'h00000000;
    else if (timer_step)
      rate_cnt_q <= rate_wrap ? 32'h00000000 : rate_cnt_q + 32'h00000001;
  end

  // Interpolated ready delay grows with the rate code
  logic [13:0] interp_delay;
  logic [13:0] interp_cnt_q;
  logic interp_busy_q;
  logic interp_done;

  assign interp_delay = 14'(INTERP_MIN + INTERP_STEP * int'(rate_code));
  assign interp_done = interp_busy_q & (interp_cnt_q >= interp_delay - 14'h0001);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interp_busy_q <= 1'b0;
      interp_cnt_q <= 14'h0000;
    end
    else if (standby || sync_mode != msc_pkg::SYNC_EXT_INTERP)
    begin
      interp_busy_q <= 1'b0;
      interp_cnt_q <= 14'h0000;
    end
    else if (sync_rise)
    begin
      interp_busy_q <= 1'b1;
      interp_cnt_q <= 14'h0000;
    end
    else if (interp_done)
    begin
      interp_busy_q <= 1'b0;
    end
    else if (interp_busy_q)
    begin
      interp_cnt_q <= interp_cnt_q + 14'h0001;
    end
  end

  logic tick;

  // Reserved sync code 11 falls back to internal timing
  always_comb
  begin
    case (sync_mode)
      msc_pkg::SYNC_EXT_DIRECT: tick = sync_rise;
      msc_pkg::SYNC_EXT_INTERP: tick = interp_done;
      default: tick = internal_tick;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sample_strobe <= 1'b0;
      data_ready <= 1'b0;
      interp_enable <= 1'b0;
    end
    else
    begin
      sample_strobe <= tick & ~standby;
      data_ready <= tick & ~standby;
      interp_enable <= sync_mode == msc_pkg::SYNC_EXT_INTERP;
    end
  end

  // Activity
  logic [15:0] activity_threshold;

  assign activity_threshold = {activity_threshold_high, activity_threshold_low_q};

  msc_activity u_activity (
    .mclk(mclk),
    .rst(rst),
    .clear(standby),
    .sample_valid(sample_valid),
    .axes(axes),
    .axis_enable(activity_axis_enable),
    .activity_threshold(activity_threshold),
    .activity_event_count(activity_event_count_q),
    .activity(activity)
  );

  // FIFO watermark: full once the stored count reaches it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      fifo_full <= 1'b0;
    else
      fifo_full <= fifo_sample_count >= fifo_wmark_q[6:0];
  end

  // Interrupt pins
  msc_pkg::msc_events_s events;
  logic [3:0] event_vec;
  logic [1:0] pin_level;

  assign events.data_ready = data_ready;
  assign events.fifo_full = fifo_full;
  assign events.overrun = buffer_overrun_event;
  assign events.activity = activity;
  // Bit order matches the map nibbles: ready, full, overrun, activity
  assign event_vec = {events.activity, events.overrun, events.fifo_full, events.data_ready};
  assign pin_level[0] = |(event_vec & int_map_q[msc_pkg::PIN_ONE_LSB +: 4]);
  assign pin_level[1] = |(event_vec & int_map_q[msc_pkg::PIN_TWO_LSB +: 4]);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_pin_one <= 1'b1;
      interrupt_pin_two <= 1'b1;
    end
    else
    begin
      interrupt_pin_one <= interrupt_polarity ? pin_level[0] : ~pin_level[0];
      interrupt_pin_two <= interrupt_polarity ? pin_level[1] : ~pin_level[1];
    end
  end

endmodule : msc_config_regs

/* File: sim/msc_config_regs_sva.sv */
// Purpose: Port-level assertions for the configuration bank
// Assumes: Mirrors of map, watermark and sync fields follow host writes
// Notes: Pins and fifo_full lag their causes by one cycle
`timescale 1ns/1ps
module msc_config_regs_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic interrupt_polarity,
  input wire logic standby,
  input wire logic sample_valid,
  input wire logic [6:0] fifo_sample_count,
  input wire logic buffer_overrun_event,
  input wire logic sync_pin,
  input wire logic data_ready,
  input wire logic highpass_enable,
  input wire logic [2:0] highpass_corner_select,
  input wire logic [3:0] rate_lowpass_select,
  input wire logic [31:0] lowpass_corner_mhz,
  input wire logic [31:0] output_sample_rate_mhz,
  input wire logic fifo_full,
  input wire logic activity,
  input wire logic interrupt_pin_one,
  input wire logic interrupt_pin_two
);
  logic [7:0] map_q;
  logic [6:0] wm_q;
  logic [1:0] sync_q;
  logic [3:0] ev;
  logic or_one;
  logic or_two;
  assign ev = {activity, buffer_overrun_event, fifo_full, data_ready};
  assign or_one = |(map_q[3:0] & ev);
  assign or_two = |(map_q[7:4] & ev);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      map_q <= 8'h00;
      wm_q <= 7'h60;
      sync_q <= 2'h0;
    end
    else if (reg_write)
    begin
      if (reg_addr == msc_pkg::ADDR_INT_MAP) map_q <= reg_wdata;
      if (reg_addr == msc_pkg::ADDR_FIFO_WMARK) wm_q <= reg_wdata[6:0];
      if (reg_addr == msc_pkg::ADDR_SYNC) sync_q <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (reg_read |-> ##[1:2] reg_rvalid)
    else $error("read strobe got no answer");
  chk_unmapped_zero: assert property (reg_read && (reg_addr < 8'h26 || reg_addr > 8'h2B)
    |-> ##[1:2] (reg_rvalid && reg_rdata == 8'h00))
    else $error("unmapped read not zero");
  chk_pin_one_map: assert property (!$past(rst) |->
    interrupt_pin_one == ($past(interrupt_polarity) ~^ $past(or_one)))
    else $error("pin one does not follow map and polarity");
  chk_pin_two_map: assert property (!$past(rst) |->
    interrupt_pin_two == ($past(interrupt_polarity) ~^ $past(or_two)))
    else $error("pin two does not follow map and polarity");
  chk_full_level: assert property (!$past(rst) |->
    fifo_full == ($past(fifo_sample_count) >= $past(wm_q)))
    else $error("fifo full does not match watermark");
  chk_direct_ready: assert property ($rose(sync_pin) && sync_q == 2'h1 && !standby
    |-> ##[2:4] data_ready)
    else $error("no data ready after sync pulse");
  chk_activity_cause: assert property (activity |->
    $past(sample_valid) || $past(sample_valid, 2))
    else $error("activity without a sample");
  chk_rate_decode: assert property (!$past(rst) && $stable(rate_lowpass_select) |->
    output_sample_rate_mhz == (32'h003D0900 >> rate_lowpass_select)
    && lowpass_corner_mhz == (32'h000F4240 >> rate_lowpass_select))
    else $error("rate decode wrong");
  chk_hpf_bypass: assert property ($stable(highpass_corner_select) |->
    highpass_enable == (highpass_corner_select != 3'h0))
    else $error("high-pass enable wrong");
  cover property (activity);
  cover property (interrupt_pin_two && interrupt_polarity);
  cover property ($rose(sync_pin) && sync_q == 2'h2);
endmodule : msc_config_regs_sva

/* File: sim/msc_host_model.sv */
// Purpose: Host side of the register port
// Assumes: Tasks are called from the bench; signals change on falling edges
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
module msc_host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge mclk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge mclk);
    reg_read = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge mclk);
    // A lost answer must never pass for a stale byte
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : msc_host_model

/* File: sim/msc_config_regs_bench.sv */
// Purpose: Self-checking bench for the configuration bank
// Assumes: Short timing parameters keep sample periods to a few cycles
// Notes: Pulses are counted on rising edges, inputs change on falling edges
`timescale 1ns/1ps
module msc_config_regs_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_d, thr_hi;
  logic reg_write, reg_read, reg_rvalid, pol, standby, sample_valid, ovr, sync_pin;
  logic ext_clock, ext_run, strobe, rdy, interp, hpf_en, full, act, pin1, pin2;
  logic [2:0] axis_en, hpf_sel;
  logic [6:0] fifo_cnt;
  logic [19:0] hpf_frac;
  logic [3:0] rate_sel;
  logic [31:0] lp_mhz, rate_mhz;
  msc_pkg::msc_axes_s axes;
  int num_errors = 0, n_compared = 0, act_n = 0, rdy_n = 0, stb_n = 0, i;
  logic [7:0] rst_vals [6] = '{8'h00, 8'h01, 8'h00, 8'h60, 8'h00, 8'h00};
  logic [7:0] rw_vals [6] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'h07};
  logic [19:0] fracs [7] = '{20'h00000, 20'h3C4D8, 20'h0F284, 20'h03CB9, 20'h00F16,
    20'h003BA, 20'h000EE};
  msc_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  msc_config_regs #(.RATE_BASE(8), .INTERP_MIN(14), .INTERP_STEP(2)) dut_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .activity_threshold_high(thr_hi), .activity_axis_enable(axis_en),
    .interrupt_polarity(pol), .standby(standby), .sample_valid(sample_valid), .axes(axes),
    .fifo_sample_count(fifo_cnt), .buffer_overrun_event(ovr), .sync_pin(sync_pin),
    .ext_clock_pin(ext_clock), .sample_strobe(strobe), .data_ready(rdy), .interp_enable(interp),
    .highpass_enable(hpf_en), .highpass_corner_select(hpf_sel),
    .highpass_corner_fraction(hpf_frac), .rate_lowpass_select(rate_sel),
    .lowpass_corner_mhz(lp_mhz), .output_sample_rate_mhz(rate_mhz), .fifo_full(full),
    .activity(act), .interrupt_pin_one(pin1), .interrupt_pin_two(pin2));
  always #20 mclk = ~mclk;
  // Outside clock stands still until a scenario selects it
  initial
  begin
    ext_clock = 1'b0;
    #7;
    forever #160 if (ext_run) ext_clock = ~ext_clock;
  end
  always @(posedge mclk)
  begin
    if (act === 1'b1) act_n++;
    if (rdy === 1'b1) rdy_n++;
    if (strobe === 1'b1) stb_n++;
  end
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rd_d);
    chk(32'(rd_d), 32'(e));
  endtask : rdchk
  task automatic smp(input logic [19:0] v);
    @(negedge mclk);
    axes.x = v;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : smp
  task automatic win(input int n, input int lo, input int hi);
    rdy_n = 0;
    stb_n = 0;
    repeat (n) @(negedge mclk);
    chk(32'(rdy_n >= lo && rdy_n <= hi), 32'h1);
    chk(32'(stb_n >= lo && stb_n <= hi), 32'h1);
  endtask : win
  task automatic syncp(input int tail);
    rdy_n = 0;
    @(negedge mclk);
    sync_pin = 1'b1;
    repeat (4) @(negedge mclk);
    sync_pin = 1'b0;
    repeat (tail) @(negedge mclk);
  endtask : syncp
  task automatic mode(input logic [7:0] v);
    standby = 1'b1;
    host_u.wr(msc_pkg::ADDR_SYNC, v);
    standby = 1'b0;
  endtask : mode
  initial
  begin
    pol = 1'b0;
    standby = 1'b1;
    sample_valid = 1'b0;
    ovr = 1'b0;
    sync_pin = 1'b0;
    ext_run = 1'b0;
    axis_en = 3'h1;
    fifo_cnt = 7'h00;
    axes = '0;
    thr_hi = 8'h00;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (i = 0; i < 6; i++) rdchk(8'h26 + 8'(i), rst_vals[i]);
    for (i = 0; i < 7; i++)
    begin
      host_u.wr(8'h26 + 8'(i), 8'hFF);
      rdchk(8'h26 + 8'(i), (i < 6) ? rw_vals[i] : 8'h00);
    end
    for (i = 0; i < 11; i++)
    begin
      host_u.wr(msc_pkg::ADDR_FILTER, 8'((i % 7) * 16 + i));
      repeat (2) @(negedge mclk);
      chk(rate_mhz, 32'h003D0900 >> i);
      chk(lp_mhz, 32'h000F4240 >> i);
      chk(32'(rate_sel), 32'(i));
      chk(32'(hpf_sel), 32'(i % 7));
      chk(32'(hpf_frac), 32'(fracs[i % 7]));
      chk(32'(hpf_en), 32'(i % 7 != 0));
    end
    host_u.wr(msc_pkg::ADDR_FILTER, 8'h00);
    host_u.wr(msc_pkg::ADDR_FIFO_WMARK, 8'h05);
    fifo_cnt = 7'h04;
    repeat (3) @(negedge mclk);
    chk(32'(full), 32'h0);
    fifo_cnt = 7'h05;
    repeat (3) @(negedge mclk);
    chk(32'(full), 32'h1);
    pol = 1'b1;
    host_u.wr(msc_pkg::ADDR_INT_MAP, 8'h02);
    repeat (2) @(negedge mclk);
    chk(32'({pin1, pin2}), 32'h2);
    ovr = 1'b1;
    host_u.wr(msc_pkg::ADDR_INT_MAP, 8'h40);
    repeat (2) @(negedge mclk);
    chk(32'({pin1, pin2}), 32'h1);
    host_u.wr(msc_pkg::ADDR_INT_MAP, 8'h42);
    repeat (2) @(negedge mclk);
    chk(32'({pin1, pin2}), 32'h3);
    pol = 1'b0;
    repeat (2) @(negedge mclk);
    chk(32'({pin1, pin2}), 32'h0);
    ovr = 1'b0;
    fifo_cnt = 7'h00;
    host_u.wr(msc_pkg::ADDR_INT_MAP, 8'h00);
    host_u.wr(msc_pkg::ADDR_THRESHOLD_LOW, 8'h10);
    host_u.wr(msc_pkg::ADDR_EVENT_COUNT, 8'h02);
    standby = 1'b0;
    act_n = 0;
    smp(20'h00088);
    smp(20'h00087);
    smp(20'h00088);
    smp(20'h00088);
    chk(32'(act_n), 32'h1);
    standby = 1'b1;
    thr_hi = 8'h01;
    @(negedge mclk);
    standby = 1'b0;
    smp(20'h00880);
    smp(20'h00888);
    smp(20'hFF778);
    chk(32'(act_n), 32'h2);
    mode(8'h00);
    win(80, 9, 11);
    mode(8'h03);
    win(80, 9, 11);
    mode(8'h01);
    win(40, 0, 0);
    syncp(10);
    chk(32'(rdy_n), 32'h1);
    mode(8'h02);
    syncp(6);
    chk(32'({interp, 7'(rdy_n)}), 32'h80);
    repeat (15) @(negedge mclk);
    chk(32'(rdy_n), 32'h1);
    ext_run = 1'b1;
    mode(8'h04);
    win(200, 2, 4);
    complete_run();
  end
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : msc_config_regs_bench
bind msc_config_regs msc_config_regs_sva chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .interrupt_polarity(interrupt_polarity), .standby(standby),
  .sample_valid(sample_valid), .fifo_sample_count(fifo_sample_count),
  .buffer_overrun_event(buffer_overrun_event), .sync_pin(sync_pin), .data_ready(data_ready),
  .highpass_enable(highpass_enable), .highpass_corner_select(highpass_corner_select),
  .rate_lowpass_select(rate_lowpass_select), .lowpass_corner_mhz(lowpass_corner_mhz),
  .output_sample_rate_mhz(output_sample_rate_mhz), .fifo_full(fifo_full),
  .activity(activity), .interrupt_pin_one(interrupt_pin_one),
  .interrupt_pin_two(interrupt_pin_two));
